// ==== logic/tk_pkg.sv ====
// package of register map, field positions and reset values for the touch key module
package tk_pkg;
    // ----------------------------------------------------------------
    // register byte addresses (one aligned word each)
    // ----------------------------------------------------------------
    localparam logic [7:0] CF_COUNT_LOW_OFF   = 8'h00;
    localparam logic [7:0] CF_COUNT_HIGH_OFF  = 8'h04;
    localparam logic [7:0] REF_CAP_LOW_OFF    = 8'h08;
    localparam logic [7:0] REF_CAP_HIGH_OFF   = 8'h0c;
    localparam logic [7:0] OSC_TUNE_OFF       = 8'h10;
    localparam logic [7:0] OSC_KEY_EN_OFF     = 8'h14;
    localparam logic [7:0] SLOT_SEQ_OFF       = 8'h18;
    localparam logic [7:0] GLOBAL_CTRL_OFF    = 8'h1c;
    // ----------------------------------------------------------------
    // field positions
    // ----------------------------------------------------------------
    localparam int FREQ_DOUBLE_BIT  = 5;
    localparam int TEST_BIT         = 4;
    localparam int HOP_CTRL_BIT     = 3;
    localparam int SLOT_CLK_BIT     = 7;
    localparam int REF_OSC_BIT      = 5;
    localparam int KEY_OSC_BIT      = 4;
    localparam int DETECT_START_BIT = 0;
    localparam int SCAN_MODE_BIT    = 1;
    localparam int SHARED_CNT_BIT   = 2;
    localparam int BUSY_BIT         = 3;
    // ----------------------------------------------------------------
    // write masks (unimplemented bits ignore writes) and reset values
    // ----------------------------------------------------------------
    localparam logic [7:0] REF_CAP_HIGH_MASK = 8'h03;
    localparam logic [7:0] OSC_TUNE_MASK     = 8'h3f;
    localparam logic [7:0] OSC_KEY_EN_MASK   = 8'hbf;
    localparam logic [7:0] GLOBAL_CTRL_MASK  = 8'h07;
    localparam logic [7:0] SLOT_SEQ_RESET    = 8'he4;
    localparam logic [7:0] ZERO_RESET        = 8'h00;
    localparam logic [15:0] COUNT_RESET      = 16'h0000;
    localparam logic [1:0]  LAST_SLOT        = 2'h3;
    localparam logic [1:0]  RESP_OKAY        = 2'h0;
    localparam logic [1:0]  RESP_SLVERR      = 2'h2;
    // capacitance step: code times 50 pF over 1024
    localparam int REF_CAP_FULL_PF = 50;
    localparam int REF_CAP_DIVISOR = 1024;
endpackage

// ==== logic/tk_count_core.sv ====
// 16-bit c/f count result with stop, slot clear and start clear behaviour
`timescale 1ns/1ps
module tk_count_core (
    input  wire logic        core_clk,
    input  wire logic        rst_n,
    input  wire logic        start_level,
    input  wire logic        busy,
    input  wire logic        manual_mode,
    input  wire logic        key_osc_tick,
    input  wire logic        slot_end,
    input  wire logic [1:0]  slot_index,
    output logic      [15:0] count_value
);
    logic [15:0] count_reg;
    logic [15:0] count_next;

    // counting only while busy; a stopped count holds until start goes low or an auto-mode slot end before slot 3 clears it
    always_comb begin
        count_next = count_reg;
        if (!start_level) begin
            count_next = tk_pkg::COUNT_RESET;
        end else if (!manual_mode && slot_end) begin
            if (slot_index != tk_pkg::LAST_SLOT) begin
                count_next = tk_pkg::COUNT_RESET;
            end
        end else if (busy && key_osc_tick) begin
            count_next = count_reg + 16'h0001;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            count_reg <= tk_pkg::COUNT_RESET;
        end else begin
            count_reg <= count_next;
        end
    end

    assign count_value = count_reg;

    a_count_start_clr: assert property (@(posedge core_clk) disable iff (!rst_n)
        !start_level |=> count_reg == 16'h0000) else $error("count not cleared by start low");
    a_count_hold_idle: assert property (@(posedge core_clk) disable iff (!rst_n)
        start_level && !busy && !slot_end |=> $stable(count_reg))
        else $error("count moved while stopped");
    a_count_last_keep: assert property (@(posedge core_clk) disable iff (!rst_n)
        start_level && !manual_mode && slot_end && slot_index == 2'h3 |=> $stable(count_reg))
        else $error("count changed at end of last slot");
endmodule // tk_count_core

// ==== logic/tk_module_ctrl.sv ====
// touch key module register set with axi4-lite slave and scan control
//
// Decided for this implementation: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/1ps
// Functional notes
// - manual mode: count stops holding at overflow
// - auto mode: count cleared after slots 0-2
// - start low clears both count bytes
// - auto mode: load next slot capacitor code
// - capacitor equals code times 50pF over 1024
// - doubling enable doubles key oscillator frequency
// - hop select one gives hardware hopping
// - hop code 000 min, 100 nominal, 111 max
// - slot clock: reference oscillator or system/4
// - auto: reference enable set on start if it clocks slots, cleared
// - reference use from source, shared, key enables
// - manual: software enables reference; busy fall clears
// - auto: key enable set on start, cleared
// - manual: software enables key oscillator; busy clears
// - four key enables in control bits 3:0
// - four slot fields choose scanned key
// - manual mode uses slot 0 field
// - unimplemented bits read zero, ignore writes
// - scan mode zero auto, one manual
// - busy set on start, cleared on overflow
// - shared select uses module 0 counter
module tk_module_ctrl (
    input  wire logic        core_clk,
    input  wire logic        rst_n,
    // axi4-lite slave
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // analogue and scan sequencer side
    input  wire logic        key_osc_tick,
    input  wire logic        own_slot_overflow,
    input  wire logic        module0_slot_overflow,
    input  wire logic        slot_end,
    input  wire logic [1:0]  slot_index,
    input  wire logic [9:0]  next_ref_cap_code,
    output logic [9:0]       ref_cap_code,
    output logic             freq_double_on,
    output logic             hop_hw_control,
    output logic [2:0]       hop_freq_code,
    output logic             slot_clk_sys_div4,
    output logic             ref_osc_on,
    output logic             key_osc_on,
    output logic [3:0]       key_enables,
    output logic [1:0]       scan_key_select,
    output logic             ref_osc_used
);
    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        BUS_IDLE = 2'b00,
        BUS_WRESP = 2'b01,
        BUS_RDATA = 2'b10
    } bus_state_t;

    typedef struct packed {
        bus_state_t  bus;
        logic        aw_seen;
        logic        w_seen;
        logic [7:0]  waddr;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic [31:0] rdata;
        logic [1:0]  resp;
        logic [9:0]  ref_cap;
        logic [7:0]  osc_tune;
        logic [7:0]  osc_key_en;
        logic [7:0]  slot_seq;
        logic        start;
        logic        manual;
        logic        shared_cnt;
        logic        busy;
    } state_t;

    state_t st_reg;
    state_t st_next;
    logic [15:0] count_value;
    logic        overflow;
    logic        start_rise;
    logic        busy_fall;
    logic        start_wr;

    // map an address to its read value; unmapped words get an error
    function automatic logic [32:0] read_word(input logic [7:0] addr, input state_t s,
                                              input logic [15:0] cnt);
        logic [32:0] r;
        r = 33'h0_0000_0000;
        unique case (addr)
            tk_pkg::CF_COUNT_LOW_OFF:  r[7:0] = cnt[7:0];
            tk_pkg::CF_COUNT_HIGH_OFF: r[7:0] = cnt[15:8];
            tk_pkg::REF_CAP_LOW_OFF:   r[7:0] = s.ref_cap[7:0];
            tk_pkg::REF_CAP_HIGH_OFF:  r[1:0] = s.ref_cap[9:8];
            tk_pkg::OSC_TUNE_OFF:      r[7:0] = s.osc_tune & tk_pkg::OSC_TUNE_MASK;
            tk_pkg::OSC_KEY_EN_OFF:    r[7:0] = s.osc_key_en & tk_pkg::OSC_KEY_EN_MASK;
            tk_pkg::SLOT_SEQ_OFF:      r[7:0] = s.slot_seq;
            tk_pkg::GLOBAL_CTRL_OFF: begin
                r[tk_pkg::DETECT_START_BIT] = s.start;
                r[tk_pkg::SCAN_MODE_BIT]    = s.manual;
                r[tk_pkg::SHARED_CNT_BIT]   = s.shared_cnt;
                r[tk_pkg::BUSY_BIT]         = s.busy;
            end
            default:                   r[32] = 1'b1;
        endcase
        return r;
    endfunction

    // ----------------------------------------------------------------
    // scan events
    // ----------------------------------------------------------------
    // shared select takes module 0's overflow instead of our own
    assign overflow = st_reg.shared_cnt ? module0_slot_overflow : own_slot_overflow;
    assign busy_fall = st_reg.busy && !st_next.busy;
    assign start_rise = !st_reg.start && st_next.start;
    assign start_wr = st_reg.bus == BUS_IDLE && st_reg.aw_seen && st_reg.w_seen
                      && st_reg.waddr == tk_pkg::GLOBAL_CTRL_OFF && st_reg.wstrb[0];

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        logic [32:0] rd;
        logic        wok;
        st_next = st_reg;
        rd = read_word(s_axi_araddr, st_reg, count_value);
        wok = 1'b0;
        // address and data may arrive in either order
        if (s_axi_awvalid && !st_reg.aw_seen && st_reg.bus == BUS_IDLE) begin
            st_next.aw_seen = 1'b1;
            st_next.waddr   = s_axi_awaddr;
        end
        if (s_axi_wvalid && !st_reg.w_seen && st_reg.bus == BUS_IDLE) begin
            st_next.w_seen = 1'b1;
            st_next.wdata  = s_axi_wdata;
            st_next.wstrb  = s_axi_wstrb;
        end
        // auto mode hardware load of next slot code
        if (!st_reg.manual && slot_end) begin
            st_next.ref_cap = next_ref_cap_code;
        end
        unique case (st_reg.bus)
            BUS_IDLE: begin
                if (st_reg.aw_seen && st_reg.w_seen) begin
                    wok = 1'b1;
                    st_next.resp = tk_pkg::RESP_OKAY;
                    if (st_reg.wstrb[0]) begin
                        unique case (st_reg.waddr)
                            tk_pkg::REF_CAP_LOW_OFF:
                                st_next.ref_cap[7:0] = st_reg.wdata[7:0];
                            tk_pkg::REF_CAP_HIGH_OFF:
                                st_next.ref_cap[9:8] = st_reg.wdata[1:0];
                            tk_pkg::OSC_TUNE_OFF:
                                st_next.osc_tune = st_reg.wdata[7:0] & tk_pkg::OSC_TUNE_MASK;
                            tk_pkg::OSC_KEY_EN_OFF:
                                st_next.osc_key_en = st_reg.wdata[7:0]
                                                     & tk_pkg::OSC_KEY_EN_MASK;
                            tk_pkg::SLOT_SEQ_OFF:
                                st_next.slot_seq = st_reg.wdata[7:0];
                            tk_pkg::GLOBAL_CTRL_OFF: begin
                                st_next.start      = st_reg.wdata[tk_pkg::DETECT_START_BIT];
                                st_next.manual     = st_reg.wdata[tk_pkg::SCAN_MODE_BIT];
                                st_next.shared_cnt = st_reg.wdata[tk_pkg::SHARED_CNT_BIT];
                            end
                            tk_pkg::CF_COUNT_LOW_OFF, tk_pkg::CF_COUNT_HIGH_OFF: begin
                            end
                            default: st_next.resp = tk_pkg::RESP_SLVERR;
                        endcase
                    end
                    st_next.aw_seen = 1'b0;
                    st_next.w_seen  = 1'b0;
                    st_next.bus     = BUS_WRESP;
                end else if (s_axi_arvalid && !st_reg.aw_seen && !st_reg.w_seen) begin
                    st_next.rdata = rd[31:0];
                    st_next.resp  = rd[32] ? tk_pkg::RESP_SLVERR : tk_pkg::RESP_OKAY;
                    st_next.bus   = BUS_RDATA;
                end
            end
            BUS_WRESP: if (s_axi_bready) st_next.bus = BUS_IDLE;
            BUS_RDATA: if (s_axi_rready) st_next.bus = BUS_IDLE;
            default:   st_next.bus = BUS_IDLE;
        endcase
        // busy: start rise sets, overflow clears; set wins on a tie
        if (!st_reg.start && st_next.start) begin
            st_next.busy = 1'b1;
        end else if (overflow) begin
            st_next.busy = 1'b0;
        end
        if (!st_next.start) begin
            st_next.busy = 1'b0;
        end
        // auto mode sets both enables at start; the reference only if it clocks the slot
        if (!st_reg.start && st_next.start && !st_next.manual) begin
            st_next.osc_key_en[tk_pkg::KEY_OSC_BIT] = 1'b1;
            if (!st_next.osc_key_en[tk_pkg::SLOT_CLK_BIT]) begin
                st_next.osc_key_en[tk_pkg::REF_OSC_BIT] = 1'b1;
            end
        end
        // busy falling turns both oscillators off in either mode
        if (st_reg.busy && !st_next.busy) begin
            st_next.osc_key_en[tk_pkg::KEY_OSC_BIT] = 1'b0;
            st_next.osc_key_en[tk_pkg::REF_OSC_BIT] = 1'b0;
        end
        if (wok) begin
            st_next.wstrb = 4'h0;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_reg            <= '0;
            st_reg.bus        <= BUS_IDLE;
            st_reg.slot_seq   <= tk_pkg::SLOT_SEQ_RESET;
            st_reg.osc_tune   <= tk_pkg::ZERO_RESET;
            st_reg.osc_key_en <= tk_pkg::ZERO_RESET;
        end else begin
            st_reg <= st_next;
        end
    end

    // ----------------------------------------------------------------
    // count result
    // ----------------------------------------------------------------
    tk_count_core u_count (
        .core_clk     (core_clk),
        .rst_n        (rst_n),
        .start_level  (st_reg.start),
        .busy         (st_reg.busy),
        .manual_mode  (st_reg.manual),
        .key_osc_tick (key_osc_tick),
        .slot_end     (slot_end),
        .slot_index   (slot_index),
        .count_value  (count_value)
    );

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign s_axi_awready = st_reg.bus == BUS_IDLE && !st_reg.aw_seen;
    assign s_axi_wready  = st_reg.bus == BUS_IDLE && !st_reg.w_seen;
    assign s_axi_arready = st_reg.bus == BUS_IDLE && !st_reg.aw_seen && !st_reg.w_seen;
    assign s_axi_bvalid  = st_reg.bus == BUS_WRESP;
    assign s_axi_rvalid  = st_reg.bus == BUS_RDATA;
    assign s_axi_bresp   = st_reg.resp;
    assign s_axi_rresp   = st_reg.resp;
    assign s_axi_rdata   = st_reg.rdata;
    // analogue trims: code drives capacitor array in steps of 50 pF / 1024
    assign ref_cap_code      = st_reg.ref_cap;
    assign freq_double_on    = st_reg.osc_tune[tk_pkg::FREQ_DOUBLE_BIT];
    assign hop_hw_control    = st_reg.osc_tune[tk_pkg::HOP_CTRL_BIT];
    // field forced to nominal code under hardware hopping so it is ignored
    assign hop_freq_code     = st_reg.osc_tune[tk_pkg::HOP_CTRL_BIT] ? 3'h4
                               : st_reg.osc_tune[2:0];
    assign slot_clk_sys_div4 = st_reg.osc_key_en[tk_pkg::SLOT_CLK_BIT];
    assign ref_osc_on        = st_reg.osc_key_en[tk_pkg::REF_OSC_BIT];
    assign key_osc_on        = st_reg.osc_key_en[tk_pkg::KEY_OSC_BIT];
    assign key_enables       = st_reg.osc_key_en[3:0];
    // manual mode muxes slot 0 field; auto mode walks the slot fields
    assign scan_key_select   = st_reg.manual ? st_reg.slot_seq[1:0]
                               : st_reg.slot_seq[2*slot_index +: 2];
    // reference needed when it clocks slots and the shared counter is off, or when any key is scanned
    assign ref_osc_used      = (!st_reg.osc_key_en[tk_pkg::SLOT_CLK_BIT]
                                && !st_reg.shared_cnt) || (|st_reg.osc_key_en[3:0]);

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    sequence s_start_rise_auto;
        start_rise && !st_next.manual;
    endsequence

    a_busy_on_start: assert property (@(posedge core_clk) disable iff (!rst_n)
        start_rise |=> st_reg.busy) else $error("busy not set by start");
    a_busy_clr_ovf: assert property (@(posedge core_clk) disable iff (!rst_n)
        st_reg.busy && overflow && !start_wr |=> !st_reg.busy)
        else $error("busy not cleared by overflow");
    a_key_osc_auto: assert property (@(posedge core_clk) disable iff (!rst_n)
        s_start_rise_auto |=> key_osc_on) else $error("key oscillator not enabled");
    a_ref_osc_auto: assert property (@(posedge core_clk) disable iff (!rst_n)
        s_start_rise_auto ##0 !st_next.osc_key_en[tk_pkg::SLOT_CLK_BIT] |=> ref_osc_on)
        else $error("reference oscillator not enabled");
    a_osc_off_fall: assert property (@(posedge core_clk) disable iff (!rst_n)
        busy_fall |=> !key_osc_on && !ref_osc_on) else $error("oscillators left on");
    a_ref_cap_load: assert property (@(posedge core_clk) disable iff (!rst_n)
        !st_reg.manual && slot_end |=> ref_cap_code == $past(next_ref_cap_code))
        else $error("capacitor code not loaded");
    a_hop_ignore: assert property (@(posedge core_clk) disable iff (!rst_n)
        hop_hw_control |-> hop_freq_code == 3'h4) else $error("hop field not ignored");
    a_manual_mux: assert property (@(posedge core_clk) disable iff (!rst_n)
        st_reg.manual |-> scan_key_select == st_reg.slot_seq[1:0])
        else $error("manual key select wrong");
    a_write_resp: assert property (@(posedge core_clk) disable iff (!rst_n)
        st_reg.bus == BUS_IDLE && st_reg.aw_seen && st_reg.w_seen |=> s_axi_bvalid)
        else $error("write response missing");
endmodule // tk_module_ctrl

// ==== test/tk_pad_model.sv ====
// touch pad model: key oscillator ticks while the oscillator is enabled
`timescale 1ns/1ps
module tk_pad_model (
    input  wire logic core_clk,
    input  wire logic rst_n,
    input  wire logic key_osc_on,
    input  wire logic run,
    input  wire logic fast,
    input  wire logic stray,
    output logic      key_osc_tick,
    output int        tick_total
);
    // ----------------------------------------
    // oscillator
    // ----------------------------------------
    logic phase_reg;
    logic swing;
    // a pad swings only while enabled; stray models an oscillator late to stop
    assign swing = run & (phase_reg | fast) & (key_osc_on | stray);
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            phase_reg    <= 1'b0;
            key_osc_tick <= 1'b0;
            tick_total   <= 0;
        end else begin
            phase_reg    <= ~phase_reg;
            key_osc_tick <= swing;
            if (swing) tick_total <= tick_total + 1;
        end
    end
endmodule // tk_pad_model

// ==== test/tk_module_ctrl_tb.sv ====
// self-checking bench for the touch key module register set
`timescale 1ns/1ps
module tk_module_ctrl_tb;
    // ----------------------------------------
    // signals
    // ----------------------------------------
    logic        core_clk = 1'b0;
    logic        rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [7:0]  s_axi_awaddr, s_axi_araddr, a, k;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd, d;
    logic [3:0]  s_axi_wstrb, key_enables;
    logic [1:0]  s_axi_bresp, s_axi_rresp, slot_index, scan_key_select, resp;
    logic [2:0]  evt, hop_freq_code;
    logic [9:0]  next_ref_cap_code, ref_cap_code;
    logic        key_osc_tick, freq_double_on, hop_hw_control, slot_clk_sys_div4;
    logic        ref_osc_on, key_osc_on, ref_osc_used, run, stray, fast;
    logic [7:0]  shadow [8];
    logic [15:0] cnt;
    int          tick_total, fail_count, checks, seed, t0, e;
    // overflow and slot end pulses share one driver vector
    wire own_slot_overflow, module0_slot_overflow, slot_end;
    assign {module0_slot_overflow, own_slot_overflow, slot_end} = evt;
    tk_module_ctrl i_dut (.core_clk, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .key_osc_tick, .own_slot_overflow,
        .module0_slot_overflow, .slot_end, .slot_index, .next_ref_cap_code, .ref_cap_code,
        .freq_double_on, .hop_hw_control, .hop_freq_code, .slot_clk_sys_div4, .ref_osc_on,
        .key_osc_on, .key_enables, .scan_key_select, .ref_osc_used);
    tk_pad_model i_pad (.core_clk, .rst_n, .key_osc_on, .run, .fast, .stray, .key_osc_tick,
        .tick_total);
    always #2.5 core_clk = ~core_clk;
    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    // both write halves offered together, each dropped once taken
    task automatic wr(input logic [7:0] adr, input logic [7:0] v);
        @(posedge core_clk);
        s_axi_awaddr  <= adr;
        s_axi_wdata   <= {24'h0, v};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        do begin
            @(posedge core_clk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!(s_axi_bvalid && s_axi_bready));
        resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    task automatic rd_reg(input logic [7:0] adr);
        @(posedge core_clk);
        s_axi_araddr  <= adr;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        do begin
            @(posedge core_clk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!(s_axi_rvalid && s_axi_rready));
        rd   = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
    task automatic rd_count;
        rd_reg(tk_pkg::CF_COUNT_LOW_OFF);
        cnt[7:0] = rd[7:0];
        rd_reg(tk_pkg::CF_COUNT_HIGH_OFF);
        cnt[15:8] = rd[7:0];
    endtask
    task automatic pulse(input logic [2:0] v);
        @(posedge core_clk);
        evt <= v;
        @(posedge core_clk);
        evt <= 3'h0;
        repeat (3) @(posedge core_clk);
    endtask
    // let the pads run; the settle cycles drain the tick pipeline
    task automatic spin(input int n);
        t0 = tick_total;
        @(posedge core_clk);
        run <= 1'b1;
        repeat (n) @(posedge core_clk);
        run <= 1'b0;
        repeat (3) @(posedge core_clk);
    endtask
    function automatic logic [7:0] masked(input logic [7:0] adr, input logic [7:0] v);
        case (adr)
            tk_pkg::REF_CAP_HIGH_OFF: return v & tk_pkg::REF_CAP_HIGH_MASK;
            tk_pkg::OSC_TUNE_OFF:     return v & tk_pkg::OSC_TUNE_MASK;
            tk_pkg::OSC_KEY_EN_OFF:   return v & tk_pkg::OSC_KEY_EN_MASK;
            default:                  return v;
        endcase
    endfunction
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // ----------------------------------------
    // watchdog and main sequence
    // ----------------------------------------
    initial begin
        #50000;
        fail_count++;
        tally_and_finish;
    end
    initial begin
        {rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {run, stray, fast, evt, slot_index, next_ref_cap_code} = '0;
        s_axi_awaddr = 8'h00;
        s_axi_araddr = 8'h00;
        s_axi_wdata  = 32'h0;
        s_axi_wstrb  = 4'h1;
        seed = 72;
        repeat (16) @(posedge core_clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 9; i++) begin
            rd_reg(8'(4 * i));
            chk("reset value", (i == 6) ? 32'(tk_pkg::SLOT_SEQ_RESET) : 32'h0, rd);
        end
        chk("unmapped resp", tk_pkg::RESP_SLVERR, resp);
        wr(tk_pkg::CF_COUNT_LOW_OFF, 8'hff);
        rd_reg(tk_pkg::CF_COUNT_LOW_OFF);
        chk("count read only", 32'h0, rd);
        $display("test reset done");
        for (int i = 0; i < 15; i++) begin
            a = 8'h08 + 8'(4 * (i % 5));
            d = $random(seed);
            if (a == tk_pkg::OSC_TUNE_OFF) d[tk_pkg::TEST_BIT] = 1'b0;
            wr(a, d[7:0]);
            shadow[a[4:2]] = masked(a, d[7:0]);
            rd_reg(a);
            chk("readback", {24'h0, shadow[a[4:2]]}, rd);
        end
        chk("ref code", {shadow[3][1:0], shadow[2]}, ref_cap_code);
        chk("doubling", shadow[4][5], freq_double_on);
        chk("slot clock", shadow[5][7], slot_clk_sys_div4);
        chk("key enables", shadow[5][3:0], key_enables);
        chk("ref used", !shadow[5][7] || |shadow[5][3:0], ref_osc_used);
        for (int c = 0; c < 16; c++) begin
            wr(tk_pkg::OSC_TUNE_OFF, 8'(c));
            chk("hop hw", c[3], hop_hw_control);
            chk("hop code", c[3] ? 3'h4 : c[2:0], hop_freq_code);
        end
        $display("test registers done");
        k = 8'h1b;
        wr(tk_pkg::SLOT_SEQ_OFF, k);
        wr(tk_pkg::GLOBAL_CTRL_OFF, 8'h02);
        chk("manual key", k[1:0], scan_key_select);
        wr(tk_pkg::GLOBAL_CTRL_OFF, 8'h00);
        for (int s = 0; s < 4; s++) begin
            slot_index <= 2'(s);
            @(posedge core_clk);
            chk("auto key", k[2*s +: 2], scan_key_select);
        end
        $display("test key select done");
        wr(tk_pkg::OSC_KEY_EN_OFF, 8'h0f);
        wr(tk_pkg::GLOBAL_CTRL_OFF, 8'h01);
        rd_reg(tk_pkg::GLOBAL_CTRL_OFF);
        chk("busy set", 1'b1, rd[tk_pkg::BUSY_BIT]);
        chk("key osc auto on", 1'b1, key_osc_on);
        chk("ref osc auto on", 1'b1, ref_osc_on);
        spin(9);
        d = $random(seed);
        next_ref_cap_code <= d[9:0];
        slot_index <= 2'h0;
        pulse(3'h1);
        rd_count;
        chk("slot 0 clear", 16'h0, cnt);
        chk("ref load", d[9:0], ref_cap_code);
        slot_index <= 2'h3;
        spin(11);
        pulse(3'h1);
        rd_count;
        chk("slot 3 hold", 16'(tick_total - t0), cnt);
        pulse(3'h4);
        wr(tk_pkg::GLOBAL_CTRL_OFF, 8'h05);
        pulse(3'h2);
        rd_reg(tk_pkg::GLOBAL_CTRL_OFF);
        chk("other counter", 8'h0d, rd);
        pulse(3'h4);
        rd_reg(tk_pkg::GLOBAL_CTRL_OFF);
        chk("busy clear", 8'h05, rd);
        chk("key osc auto off", 1'b0, key_osc_on);
        chk("ref osc auto off", 1'b0, ref_osc_on);
        wr(tk_pkg::GLOBAL_CTRL_OFF, 8'h00);
        rd_count;
        chk("start low clear", 16'h0, cnt);
        $display("test auto scan done");
        fast <= 1'b1;
        wr(tk_pkg::OSC_KEY_EN_OFF, 8'h31);
        wr(tk_pkg::GLOBAL_CTRL_OFF, 8'h03);
        spin(13);
        e = tick_total - t0;
        pulse(3'h2);
        chk("key osc manual off", 1'b0, key_osc_on);
        chk("ref osc manual off", 1'b0, ref_osc_on);
        stray <= 1'b1;
        spin(8);
        stray <= 1'b0;
        rd_count;
        chk("manual hold", 16'(e), cnt);
        wr(tk_pkg::GLOBAL_CTRL_OFF, 8'h02);
        rd_count;
        chk("start low clear", 16'h0, cnt);
        $display("test manual scan done");
        tally_and_finish;
    end
endmodule // tk_module_ctrl_tb
